// [verilog/oscsc_pkg.sv]
// Shared constants and types for the oscillator source control block
package oscsc_pkg;

    // ------------------------------------------------------------------
    // Register port and map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [3:0] SYSCLK_CTRL_ADDR = 4'h0;
    localparam logic [3:0] FAST_RC_CTRL_ADDR = 4'h1;
    localparam logic [3:0] CRYSTAL_CTRL_ADDR = 4'h2;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // sysclk_ctrl_reg fields
    localparam int SEL_MSB = 7;
    localparam int SEL_LSB = 5;
    localparam int SRC_BIT = 3;
    localparam int HALT_BIT = 0;
    localparam logic [2:0] SEL_RST = 3'h0;
    localparam logic [2:0] SEL_SLOW = 3'h7;
    localparam logic SRC_RST = 1'b0;
    localparam logic SRC_CRYSTAL = 1'b1;

    // fast_rc_ctrl_reg fields
    localparam int FREQ_MSB = 3;
    localparam int FREQ_LSB = 2;
    localparam logic [1:0] FREQ_8MHZ = 2'h0;
    localparam logic [1:0] FREQ_12MHZ = 2'h1;
    localparam logic [1:0] FREQ_16MHZ = 2'h2;
    localparam logic [1:0] FREQ_RST = FREQ_8MHZ;

    // Crystal control register fields
    localparam int XEN_BIT = 0;
    localparam int XSP_BIT = 1;
    localparam int XRDY_BIT = 2;
    localparam int XPIN_BIT = 4;
    localparam logic XSP_RST = 1'b1;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int MCLK_PERIOD_NS = 10;
    localparam int CRYSTAL_SU_FAST_NS = 20000;
    localparam int CRYSTAL_SU_FAST_CYCLES =
        (CRYSTAL_SU_FAST_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int CRYSTAL_SU_SLOW_NS = 200000;
    localparam int CRYSTAL_SU_SLOW_CYCLES_DEF =
        (CRYSTAL_SU_SLOW_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int XCNT_W = 20;
    localparam logic [XCNT_W-1:0] XCNT_ONE = 20'h0_0001;

    // Fast clock divide chain: ratios 1,2,4,..,64
    localparam int DIV_STAGES = 7;

    // ------------------------------------------------------------------
    // Crystal oscillator state, Gray along off -> starting -> ready
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        OSCSC_X_OFF = 2'b00,
        OSCSC_X_STARTING = 2'b01,
        OSCSC_X_READY = 2'b11
    } oscsc_xstate_type;

endpackage : oscsc_pkg

// [verilog/oscsc_fast_div.sv]
// Divide chain for the fast RC clock level, ratios 1 to 64
`timescale 1ns/1ns
module oscsc_fast_div
    import oscsc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic fast_lvl,
    output logic [DIV_STAGES-1:0] div_lvl
);

    typedef struct packed {
        logic [DIV_STAGES-1:0] stage;
        logic [DIV_STAGES-1:0] last;
    } oscsc_div_type;

    oscsc_div_type state_reg;
    oscsc_div_type state_next;
    logic [DIV_STAGES-1:0] toggle;

    // ------------------------------------------------------------------
    // Stage 0 copies the fast level; each later stage toggles on the falling edge of the one before
    // ------------------------------------------------------------------
    assign toggle[0] = 1'b0;
    genvar k;
    generate
        for (k = 1; k < DIV_STAGES; k++)
        begin : g_stage
            assign toggle[k] = state_reg.last[k-1] & ~state_reg.stage[k-1];
        end
    endgenerate

    always_comb
    begin
        state_next = state_reg;
        state_next.last = state_reg.stage;
        state_next.stage = state_reg.stage ^ toggle;
        state_next.stage[0] = fast_lvl;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign div_lvl = state_reg.stage;

endmodule : oscsc_fast_div

// [verilog/oscsc_clk_mux.sv]
// Glitch-free system clock selector with stop control
`timescale 1ns/1ns
module oscsc_clk_mux
    import oscsc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] src_lvl,
    input wire logic [2:0] sel,
    input wire logic halt,
    output logic clk_out
);

    typedef struct packed {
        logic [2:0] active;
        logic out;
    } oscsc_mux_type;

    oscsc_mux_type state_reg;
    oscsc_mux_type state_next;

    // ------------------------------------------------------------------
    // Switch only while both old output and new source are low, so no
    // phase is ever shortened; a low phase may stretch instead
    // ------------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        if (!state_reg.out && !src_lvl[sel])
            state_next.active = sel;
        // Stop is taken only in a low phase to avoid a runt high
        if (!state_reg.out && halt)
            state_next.out = 1'b0;
        else
            state_next.out = src_lvl[state_next.active];
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            state_reg <= '{active: SEL_RST, out: 1'b0};
        else
            state_reg <= state_next;
    end

    assign clk_out = state_reg.out;

endmodule : oscsc_clk_mux

// [verilog/oscsc_top.sv]
// Oscillator source control: registers, crystal start-up and clock routing
`timescale 1ns/1ns

// Behaviour
// - Fast RC runs at 8, 12 or 16 MHz by two-bit select.
// - Three-bit select picks fast or slow system clock, changeable any time.
// - One bit picks crystal or slow RC as the slow clock.
// - Writing enable with the pins given to the oscillator starts the crystal; usable only after start-up delay.
// - Crystal mode bit: 0 low power, 1 speed-up.
// - Clearing speed-up after start keeps the crystal running uninterrupted.
// - Crystal mode writes ignored while crystal is the system clock.
// - Crystal valid in both modes; low power only lengthens start-up.
// - Pin-sharing bit decides crystal pins use: oscillator or general I/O.
// - Oscillators also feed watchdog and time base clocks.
// - Sleep or idle stops system clock; slow clock keeps timers running.
// - Slow RC oscillator always stays running for the watchdog.
// - Fast source divided by 1 to 64 per clock select field.
module oscsc_top
    import oscsc_pkg::*;
#(
    parameter int CRYSTAL_SU_SLOW_CYCLES = CRYSTAL_SU_SLOW_CYCLES_DEF
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [DATA_W-1:0] rd_data,
    input wire logic fast_rc_lvl,
    input wire logic crystal_lvl,
    input wire logic slow_rc_lvl,
    input wire logic wake_event,
    output logic sysclk_out,
    output logic wdt_clk_out,
    output logic timebase_clk_out,
    output logic [1:0] fast_rc_freq_sel,
    output logic crystal_enable_out,
    output logic crystal_speedup_out,
    output logic crystal_ready_out,
    output logic crystal_pin_osc_out,
    output logic slow_rc_enable_out
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] sysclk_select;
        logic slow_source_select;
        logic halt;
        logic [1:0] freq;
        logic crystal_enable;
        logic crystal_speedup;
        logic pin_osc;
        oscsc_xstate_type xstate;
        logic [XCNT_W-1:0] xcnt;
        logic [DATA_W-1:0] rdata;
        logic wdt;
        logic timebase;
        logic slow_rc_en;
    } oscsc_state_type;

    oscsc_state_type state_reg;
    oscsc_state_type state_next;

    logic [DIV_STAGES-1:0] div_lvl;
    logic [7:0] src_lvl;
    logic slow_lvl;
    logic crystal_usable;
    logic crystal_run;
    logic [XCNT_W-1:0] xlimit;

    localparam logic [XCNT_W-1:0] XLIM_FAST = XCNT_W'(CRYSTAL_SU_FAST_CYCLES);
    localparam logic [XCNT_W-1:0] XLIM_SLOW = XCNT_W'(CRYSTAL_SU_SLOW_CYCLES);

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic logic crystal_is_sysclk(input logic [2:0] sel, input logic slow_src);
        crystal_is_sysclk = (sel == SEL_SLOW) && (slow_src == SRC_CRYSTAL);
    endfunction : crystal_is_sysclk

    function automatic logic [DATA_W-1:0] read_word(input oscsc_state_type s,
                                                    input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] w;
        w = READ_ZERO;
        unique case (a)
            SYSCLK_CTRL_ADDR:
            begin
                w[SEL_MSB:SEL_LSB] = s.sysclk_select;
                w[SRC_BIT] = s.slow_source_select;
                w[HALT_BIT] = s.halt;
            end
            FAST_RC_CTRL_ADDR:
            begin
                w[FREQ_MSB:FREQ_LSB] = s.freq;
            end
            CRYSTAL_CTRL_ADDR:
            begin
                w[XEN_BIT] = s.crystal_enable;
                w[XSP_BIT] = s.crystal_speedup;
                w[XRDY_BIT] = (s.xstate == OSCSC_X_READY);
                w[XPIN_BIT] = s.pin_osc;
            end
            default:
            begin
                w = READ_ZERO;
            end
        endcase
        read_word = w;
    endfunction : read_word

    // ------------------------------------------------------------------
    // Clock sources
    // ------------------------------------------------------------------
    // divide ratios
    oscsc_fast_div u_fast_div (
        .mclk(mclk),
        .rst(rst),
        .fast_lvl(fast_rc_lvl),
        .div_lvl(div_lvl)
    );

    assign crystal_usable = (state_reg.xstate == OSCSC_X_READY);

    // oscillator runs only when its pins are given to it
    assign crystal_run = state_reg.crystal_enable & state_reg.pin_osc;

    assign slow_lvl = (state_reg.slow_source_select == SRC_CRYSTAL) ?
                      (crystal_lvl & crystal_usable) : slow_rc_lvl;

    // codes below slow pick a fast ratio, top code picks slow clock
    always_comb
    begin
        src_lvl = '0;
        src_lvl[DIV_STAGES-1:0] = div_lvl;
        src_lvl[SEL_SLOW] = slow_lvl;
    end

    // low power only stretches the wait, never changes validity
    assign xlimit = state_reg.crystal_speedup ? XLIM_FAST : XLIM_SLOW;

    oscsc_clk_mux u_clk_mux (
        .mclk(mclk),
        .rst(rst),
        .src_lvl(src_lvl),
        .sel(state_reg.sysclk_select),
        .halt(state_reg.halt),
        .clk_out(sysclk_out)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        state_next.rdata = READ_ZERO;

        // wake clears a stop request; a same-cycle write wins
        if (wake_event)
            state_next.halt = 1'b0;

        if (rd_stb)
            state_next.rdata = read_word(state_reg, addr);

        if (wr_stb)
        begin
            unique case (addr)
                SYSCLK_CTRL_ADDR:
                begin
                    state_next.sysclk_select = wr_data[SEL_MSB:SEL_LSB];
                    state_next.slow_source_select = wr_data[SRC_BIT];
                    // stop system clock on sleep/idle entry
                    state_next.halt = wr_data[HALT_BIT];
                end
                FAST_RC_CTRL_ADDR:
                begin
                    // the unused code is refused, frequency stays put
                    if (wr_data[FREQ_MSB:FREQ_LSB] == FREQ_8MHZ ||
                        wr_data[FREQ_MSB:FREQ_LSB] == FREQ_12MHZ ||
                        wr_data[FREQ_MSB:FREQ_LSB] == FREQ_16MHZ)
                        state_next.freq = wr_data[FREQ_MSB:FREQ_LSB];
                end
                CRYSTAL_CTRL_ADDR:
                begin
                    state_next.crystal_enable = wr_data[XEN_BIT];
                    state_next.pin_osc = wr_data[XPIN_BIT];
                    // mode frozen while crystal drives the system clock
                    if (!crystal_is_sysclk(state_reg.sysclk_select,
                                           state_reg.slow_source_select))
                        // mode bit: 0 low power, 1 speed-up
                        state_next.crystal_speedup = wr_data[XSP_BIT];
                end
                default:
                begin
                    state_next.rdata = state_next.rdata;
                end
            endcase
        end

        // start-up delay before the crystal is usable
        unique case (state_reg.xstate)
            OSCSC_X_OFF:
            begin
                state_next.xcnt = '0;
                if (crystal_run)
                    state_next.xstate = OSCSC_X_STARTING;
            end
            OSCSC_X_STARTING:
            begin
                if (!crystal_run)
                begin
                    state_next.xstate = OSCSC_X_OFF;
                    state_next.xcnt = '0;
                end
                else if (state_reg.xcnt + XCNT_ONE >= xlimit)
                    state_next.xstate = OSCSC_X_READY;
                else
                    state_next.xcnt = state_reg.xcnt + XCNT_ONE;
            end
            OSCSC_X_READY:
            begin
                // mode change keeps the crystal running
                if (!crystal_run)
                    state_next.xstate = OSCSC_X_OFF;
            end
            default:
            begin
                state_next.xstate = OSCSC_X_OFF;
                state_next.xcnt = '0;
            end
        endcase

        // watchdog from slow RC, time base from slow clock
        state_next.wdt = slow_rc_lvl;
        // time base keeps going while the system clock is stopped
        state_next.timebase = slow_lvl;
        state_next.slow_rc_en = 1'b1;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state_reg.sysclk_select <= SEL_RST;
            state_reg.slow_source_select <= SRC_RST;
            state_reg.halt <= 1'b0;
            state_reg.freq <= FREQ_RST;
            state_reg.crystal_enable <= 1'b0;
            state_reg.crystal_speedup <= XSP_RST;
            state_reg.pin_osc <= 1'b0;
            state_reg.xstate <= OSCSC_X_OFF;
            state_reg.xcnt <= '0;
            state_reg.rdata <= READ_ZERO;
            state_reg.wdt <= 1'b0;
            state_reg.timebase <= 1'b0;
            state_reg.slow_rc_en <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rd_data = state_reg.rdata;
    assign wdt_clk_out = state_reg.wdt;
    assign timebase_clk_out = state_reg.timebase;
    // frequency code to the fast RC trim
    assign fast_rc_freq_sel = state_reg.freq;
    assign crystal_enable_out = state_reg.crystal_enable;
    assign crystal_speedup_out = state_reg.crystal_speedup;
    assign crystal_ready_out = (state_reg.xstate == OSCSC_X_READY);
    assign crystal_pin_osc_out = state_reg.pin_osc;
    assign slow_rc_enable_out = state_reg.slow_rc_en;

endmodule : oscsc_top

// [testbench/oscsc_assertions.sv]
// Port-level checks for the oscillator source control block
`timescale 1ns/1ns
module oscsc_assertions
    import oscsc_pkg::*;
#(
    parameter int CRYSTAL_SU_SLOW_CYCLES = CRYSTAL_SU_SLOW_CYCLES_DEF
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [DATA_W-1:0] rd_data,
    input wire logic slow_rc_lvl,
    input wire logic wdt_clk_out,
    input wire logic [1:0] fast_rc_freq_sel,
    input wire logic crystal_enable_out,
    input wire logic crystal_ready_out,
    input wire logic crystal_pin_osc_out,
    input wire logic slow_rc_enable_out
);
    logic [11:0] run_cnt_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // Helper count
    // ------------------------------------------------------------------
    // Saturates so a long-running crystal never wraps back under the bound
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            run_cnt_reg <= 12'h000;
        else if (!(crystal_enable_out && crystal_pin_osc_out))
            run_cnt_reg <= 12'h000;
        else if (run_cnt_reg != 12'hfff)
            run_cnt_reg <= run_cnt_reg + 12'h001;
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_rd_idle_zero: assert property (!$past(rd_stb) |-> rd_data == READ_ZERO)
        else $error("read data not zero outside its slot");
    a_freq_legal: assert property (fast_rc_freq_sel != 2'h3)
        else $error("fast rc frequency code out of range");
    a_freq_hold: assert property (!$past(wr_stb) |-> $stable(fast_rc_freq_sel))
        else $error("fast rc frequency changed without a write");
    a_slow_rc_on: assert property (slow_rc_enable_out == 1'h1)
        else $error("slow rc oscillator disabled");
    a_wdt_follows: assert property (!$past(rst) |-> wdt_clk_out == $past(slow_rc_lvl))
        else $error("watchdog clock does not follow slow rc");
    a_ready_min: assert property ($rose(crystal_ready_out) |->
        int'(run_cnt_reg) + 4 >= CRYSTAL_SU_SLOW_CYCLES)
        else $error("crystal ready before start-up delay");
    // The run count stands in for a long delay range; 2100 cycles covers speed-up mode but not the default 20000-cycle low power start-up
    a_ready_bound: assert property (run_cnt_reg >= 12'h0834 |-> crystal_ready_out)
        else $error("crystal never became ready");
    // Ready is a registered state, so it drops one edge after the enable output
    a_en_drop: assert property ($fell(crystal_enable_out) |=> ##1 !crystal_ready_out)
        else $error("crystal ready after enable cleared");
    a_pin_drop: assert property ($fell(crystal_pin_osc_out) |=> ##1 !crystal_ready_out)
        else $error("crystal ready after pins released");
endmodule : oscsc_assertions

bind oscsc_top oscsc_assertions #(.CRYSTAL_SU_SLOW_CYCLES(CRYSTAL_SU_SLOW_CYCLES))
    oscsc_assertions_inst (.mclk(mclk), .rst(rst), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rd_data(rd_data), .slow_rc_lvl(slow_rc_lvl), .wdt_clk_out(wdt_clk_out),
    .fast_rc_freq_sel(fast_rc_freq_sel), .crystal_enable_out(crystal_enable_out),
    .crystal_ready_out(crystal_ready_out), .crystal_pin_osc_out(crystal_pin_osc_out),
    .slow_rc_enable_out(slow_rc_enable_out));

// [testbench/oscsc_top_tb.sv]
// Self-checking bench for the oscillator source control block
`timescale 1ns/1ns
module oscsc_top_tb;
    import oscsc_pkg::*;
    localparam int SLOW_CYC = 50;
    localparam int TIMEOUT_CYC = 30000;
    logic mclk = 1'h0;
    logic rst = 1'h1;
    logic [ADDR_W-1:0] addr = 4'h0;
    logic [DATA_W-1:0] wr_data = 8'h00;
    logic wr_stb = 1'h0;
    logic rd_stb = 1'h0;
    logic fast_rc_lvl = 1'h0;
    logic crystal_lvl = 1'h0;
    logic slow_rc_lvl = 1'h0;
    logic wake_event = 1'h0;
    logic xtal_prev = 1'h0;
    logic slow_rc_prev = 1'h0;
    logic [DATA_W-1:0] rd_data;
    logic sysclk_out, wdt_clk_out, timebase_clk_out;
    logic [1:0] fast_rc_freq_sel;
    logic crystal_enable_out, crystal_speedup_out, crystal_ready_out;
    logic crystal_pin_osc_out, slow_rc_enable_out;
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;

    oscsc_top #(.CRYSTAL_SU_SLOW_CYCLES(SLOW_CYC)) oscsc_top_inst (.mclk(mclk), .rst(rst),
        .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rd_data(rd_data), .fast_rc_lvl(fast_rc_lvl), .crystal_lvl(crystal_lvl),
        .slow_rc_lvl(slow_rc_lvl), .wake_event(wake_event), .sysclk_out(sysclk_out),
        .wdt_clk_out(wdt_clk_out), .timebase_clk_out(timebase_clk_out),
        .fast_rc_freq_sel(fast_rc_freq_sel), .crystal_enable_out(crystal_enable_out),
        .crystal_speedup_out(crystal_speedup_out), .crystal_ready_out(crystal_ready_out),
        .crystal_pin_osc_out(crystal_pin_osc_out), .slow_rc_enable_out(slow_rc_enable_out));

    always #5 mclk = ~mclk;

    // ------------------------------------------------------------------
    // Oscillator levels and hang guard
    // ------------------------------------------------------------------
    // Fast rc toggles every cycle, crystal period 4, slow rc period 8
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        fast_rc_lvl <= ~fast_rc_lvl;
        crystal_lvl <= cyc[1];
        slow_rc_lvl <= cyc[2];
        xtal_prev <= crystal_lvl;
        slow_rc_prev <= slow_rc_lvl;
        if (cyc == TIMEOUT_CYC)
        begin
            errors++;
            finish_test();
        end
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check_val

    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'h1;
        @(posedge mclk);
        wr_stb <= 1'h0;
        #1;
    endtask : reg_write

    task automatic reg_check(input logic [3:0] a, input logic [7:0] exp);
        @(posedge mclk);
        addr <= a;
        rd_stb <= 1'h1;
        @(posedge mclk);
        rd_stb <= 1'h0;
        #1;
        check_val("register read", 16'(exp), 16'(rd_data));
    endtask : reg_check

    task automatic wait_ready(input int limit, output int n);
        n = 0;
        while (crystal_ready_out !== 1'h1 && n < limit)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
    endtask : wait_ready

    task automatic count_rises(input int len, output int n);
        logic prev;
        n = 0;
        prev = sysclk_out;
        repeat (len)
        begin
            @(posedge mclk);
            #1;
            if (sysclk_out === 1'h1 && prev === 1'h0)
                n++;
            prev = sysclk_out;
        end
    endtask : count_rises

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_reset_values;
        reg_check(SYSCLK_CTRL_ADDR, 8'h00);
        reg_check(FAST_RC_CTRL_ADDR, 8'h00);
        reg_check(CRYSTAL_CTRL_ADDR, 8'h02);
        reg_check(4'hf, 8'h00);
        check_val("slow rc enable", 16'h0001, 16'(slow_rc_enable_out));
    endtask : test_reset_values

    task automatic test_freq;
        for (int i = 0; i < 3; i++)
        begin
            reg_write(FAST_RC_CTRL_ADDR, 8'(i << FREQ_LSB));
            check_val("freq sel", 16'(i), 16'(fast_rc_freq_sel));
        end
        // Code 3 is refused, the last legal code stays
        reg_write(FAST_RC_CTRL_ADDR, 8'h0c);
        reg_check(FAST_RC_CTRL_ADDR, 8'h08);
    endtask : test_freq

    task automatic test_crystal_start;
        int n;
        reg_write(CRYSTAL_CTRL_ADDR, 8'h11);
        check_val("speedup low power", 16'h0000, 16'(crystal_speedup_out));
        wait_ready(200, n);
        check_val("low power start", 16'h0001, 16'(n >= SLOW_CYC - 4 && n <= SLOW_CYC + 4));
        reg_check(CRYSTAL_CTRL_ADDR, 8'h15);
        reg_write(CRYSTAL_CTRL_ADDR, 8'h10);
        repeat (2) @(posedge mclk);
        #1;
        check_val("ready after stop", 16'h0000, 16'(crystal_ready_out));
        reg_write(CRYSTAL_CTRL_ADDR, 8'h13);
        wait_ready(2100, n);
        check_val("speedup start", 16'h0001, 16'(n >= 1990 && n <= 2010));
        reg_write(CRYSTAL_CTRL_ADDR, 8'h11);
        repeat (20) @(posedge mclk);
        #1;
        check_val("ready in low power", 16'h0001, 16'(crystal_ready_out));
        check_val("speedup cleared", 16'h0000, 16'(crystal_speedup_out));
    endtask : test_crystal_start

    task automatic test_mode_lock;
        reg_write(SYSCLK_CTRL_ADDR, 8'he8);
        reg_write(CRYSTAL_CTRL_ADDR, 8'h13);
        check_val("speedup locked", 16'h0000, 16'(crystal_speedup_out));
        repeat (8)
        begin
            @(posedge mclk);
            #1;
            check_val("timebase crystal", 16'(xtal_prev), 16'(timebase_clk_out));
        end
        reg_write(SYSCLK_CTRL_ADDR, 8'h00);
        reg_write(CRYSTAL_CTRL_ADDR, 8'h13);
        check_val("speedup unlocked", 16'h0001, 16'(crystal_speedup_out));
        repeat (8)
        begin
            @(posedge mclk);
            #1;
            check_val("timebase slow rc", 16'(slow_rc_prev), 16'(timebase_clk_out));
        end
        reg_write(CRYSTAL_CTRL_ADDR, 8'h03);
        check_val("pin to io", 16'h0000, 16'(crystal_pin_osc_out));
        repeat (2) @(posedge mclk);
        #1;
        check_val("ready pins io", 16'h0000, 16'(crystal_ready_out));
    endtask : test_mode_lock

    task automatic test_sysclk;
        int n;
        int e;
        for (int s = 0; s < 8; s++)
        begin
            reg_write(SYSCLK_CTRL_ADDR, 8'(s << SEL_LSB));
            repeat (300) @(posedge mclk);
            count_rises(512, n);
            e = (s == 7) ? 64 : 512 >> (s + 1);
            // One edge of slack for where the window starts
            check_val("sysclk rises", 16'(e), 16'((n == e + 1 || n == e - 1) ? e : n));
        end
        reg_write(SYSCLK_CTRL_ADDR, 8'h01);
        repeat (10) @(posedge mclk);
        count_rises(50, n);
        check_val("halted rises", 16'h0000, 16'(n));
        @(posedge mclk);
        wake_event <= 1'h1;
        @(posedge mclk);
        wake_event <= 1'h0;
        repeat (10) @(posedge mclk);
        count_rises(50, n);
        check_val("woken rises", 16'h0001, 16'(n >= 24 && n <= 26));
    endtask : test_sysclk

    task automatic finish_test;
        if (errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    initial
    begin
        repeat (6) @(posedge mclk);
        rst <= 1'h0;
        test_reset_values();
        test_freq();
        test_crystal_start();
        test_mode_lock();
        test_sysclk();
        finish_test();
    end
endmodule : oscsc_top_tb
